//--- hdl/flcu_pkg.sv
// Purpose: shared constants for the fast loop counter unit
// Assumes: four counter words, one loop call per word, single clock
// Notes:   no printed reset value exists, so the counter words clear to zero
`default_nettype none
package flcu_pkg;
  localparam int unsigned                  FLCU_NUM_WORDS   = 4;
  localparam int unsigned                  FLCU_IDX_W       = 2;
  localparam int unsigned                  FLCU_WORD_W      = 16;
  localparam int unsigned                  FLCU_CC_W        = 8;

  // system data word numbers and call numbers, numbered consecutively
  localparam int unsigned                  FLCU_SDW_BASE    = 60;
  localparam int unsigned                  FLCU_CALL_BASE   = 160;

  // index of each counter word inside the unit
  localparam logic [FLCU_IDX_W-1:0]        FLCU_IDX_A       = 2'h0;
  localparam logic [FLCU_IDX_W-1:0]        FLCU_IDX_B       = 2'h1;
  localparam logic [FLCU_IDX_W-1:0]        FLCU_IDX_C       = 2'h2;
  localparam logic [FLCU_IDX_W-1:0]        FLCU_IDX_D       = 2'h3;

  localparam logic [FLCU_WORD_W-1:0]       FLCU_WORD_RST    = 16'h0000;
  localparam logic [FLCU_WORD_W-1:0]       FLCU_WORD_ONE    = 16'h0001;
  localparam logic [FLCU_WORD_W-1:0]       FLCU_WORD_MAX    = 16'hFFFF;
  localparam logic [FLCU_CC_W-1:0]         FLCU_CC_RST      = 8'h00;
  localparam logic [FLCU_CC_W-1:0]         FLCU_CC_CLEARED  = 8'h00;
  localparam logic                         FLCU_RLO_RST     = 1'b0;
endpackage : flcu_pkg
`default_nettype wire

//--- hdl/flcu_loop_eval.sv
// Purpose: decrement one counter value and derive the loop flag
// Assumes: purely combinational, used by the unit's call path
// Notes:   wraps zero to all ones on purpose
`default_nettype none
module flcu_loop_eval (
  input  wire logic [flcu_pkg::FLCU_WORD_W-1:0] curValue,
  output logic      [flcu_pkg::FLCU_WORD_W-1:0] decValue,
  output logic                                  nonZero
);
  import flcu_pkg::*;

  always_comb begin
    decValue = curValue - FLCU_WORD_ONE;
    nonZero  = (decValue != FLCU_WORD_RST);
  end
endmodule : flcu_loop_eval
`default_nettype wire

//--- hdl/flcu_count_word.sv
// Purpose: one 16-bit loop counter word
// Assumes: write and decrement requests come from the same clock domain
// Notes:   a decrement in the same cycle as a write wins; the write is dropped
`default_nettype none
module flcu_count_word (
  input  wire logic                              sys_clk,
  input  wire logic                              arst_n,
  input  wire logic                              ce,
  input  wire logic                              wrEn,
  input  wire logic [flcu_pkg::FLCU_WORD_W-1:0]  wrData,
  input  wire logic                              decEn,
  input  wire logic [flcu_pkg::FLCU_WORD_W-1:0]  decValue,
  output logic      [flcu_pkg::FLCU_WORD_W-1:0]  value_ff
);
  import flcu_pkg::*;

  logic [FLCU_WORD_W-1:0] nxt_value;

  always_comb begin
    nxt_value = value_ff;
    if (decEn) begin
      nxt_value = decValue;
    end else if (wrEn) begin
      nxt_value = wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      value_ff <= FLCU_WORD_RST;
    end else if (ce) begin
      value_ff <= nxt_value;
    end
  end
endmodule : flcu_count_word
`default_nettype wire

//--- hdl/flcu_fast_loop_counter_unit.sv
// Purpose: four loop counter words with their loop calls
// Assumes: the processor core drives all requests from sys_clk logic
// Notes:   accumulators are not wired to this unit at all, so they cannot change
`default_nettype none
module flcu_fast_loop_counter_unit (
  input  wire logic                                sys_clk,
  input  wire logic                                arst_n,
  input  wire logic                                ce,
  // system data word access
  input  wire logic                                sdwWrEn,
  input  wire logic [flcu_pkg::FLCU_IDX_W-1:0]     sdwWrIdx,
  input  wire logic [flcu_pkg::FLCU_WORD_W-1:0]    sdwWrData,
  input  wire logic                                sdwRdEn,
  input  wire logic [flcu_pkg::FLCU_IDX_W-1:0]     sdwRdIdx,
  output logic      [flcu_pkg::FLCU_WORD_W-1:0]    sdwRdData_ff,
  output logic                                     sdwRdValid_ff,
  // loop calls
  input  wire logic                                loopCallEn,
  input  wire logic [flcu_pkg::FLCU_IDX_W-1:0]     loopCallIdx,
  output logic                                     loopCallDone_ff,
  output logic                                     loopCallError_ff,
  // condition state shared with the core
  input  wire logic                                rloWrEn,
  input  wire logic                                rloWrData,
  input  wire logic                                ccWrEn,
  input  wire logic [flcu_pkg::FLCU_CC_W-1:0]      ccWrData,
  output logic                                     resultOfLogicBit_ff,
  output logic      [flcu_pkg::FLCU_CC_W-1:0]      condCodes_ff
);
  import flcu_pkg::*;

  logic [FLCU_WORD_W-1:0] wordValue [FLCU_NUM_WORDS];
  logic [FLCU_WORD_W-1:0] selValue;
  logic [FLCU_WORD_W-1:0] decValue;
  logic                   nonZero;

  logic                   nxt_rlo;
  logic [FLCU_CC_W-1:0]   nxt_cc;
  logic                   nxt_done;
  logic                   nxt_error;
  logic [FLCU_WORD_W-1:0] nxt_rdData;
  logic                   nxt_rdValid;

  // the call index picks exactly one word; no other word is touched
  always_comb begin
    selValue = wordValue[loopCallIdx];
  end

  flcu_loop_eval u_eval (
    .curValue (selValue),
    .decValue (decValue),
    .nonZero  (nonZero)
  );

  genvar gi;
  generate
    for (gi = 0; gi < FLCU_NUM_WORDS; gi++) begin : g_word
      flcu_count_word u_word (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .wrEn     (sdwWrEn && (sdwWrIdx == FLCU_IDX_W'(gi))),
        .wrData   (sdwWrData),
        .decEn    (loopCallEn && (loopCallIdx == FLCU_IDX_W'(gi))),
        .decValue (decValue),
        .value_ff (wordValue[gi])
      );
    end
  endgenerate

  // condition state: a call overrides any core write in the same cycle
  always_comb begin
    nxt_rlo   = resultOfLogicBit_ff;
    nxt_cc    = condCodes_ff;
    nxt_done  = 1'b0;
    nxt_error = 1'b0;
    // a call touches only its word, the flag and the codes; no accumulator path
    if (loopCallEn) begin
      nxt_rlo  = nonZero;
      nxt_cc   = FLCU_CC_CLEARED;
      nxt_done = 1'b1;
    end else begin
      if (rloWrEn) begin
        nxt_rlo = rloWrData;
      end
      if (ccWrEn) begin
        nxt_cc = ccWrData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      resultOfLogicBit_ff <= FLCU_RLO_RST;
      condCodes_ff        <= FLCU_CC_RST;
      loopCallDone_ff     <= 1'b0;
      loopCallError_ff    <= 1'b0;
    end else if (ce) begin
      resultOfLogicBit_ff <= nxt_rlo;
      condCodes_ff        <= nxt_cc;
      loopCallDone_ff     <= nxt_done;
      loopCallError_ff    <= nxt_error;
    end
  end

  // readback shows the stored word as of the read cycle
  always_comb begin
    nxt_rdData  = sdwRdData_ff;
    nxt_rdValid = sdwRdEn;
    if (sdwRdEn) begin
      nxt_rdData = wordValue[sdwRdIdx];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdwRdData_ff  <= FLCU_WORD_RST;
      sdwRdValid_ff <= 1'b0;
    end else if (ce) begin
      sdwRdData_ff  <= nxt_rdData;
      sdwRdValid_ff <= nxt_rdValid;
    end
  end
endmodule : flcu_fast_loop_counter_unit
`default_nettype wire

//--- sim/flcu_fast_loop_counter_unit_sva.sv
// Purpose: port checks of the loop counter unit
// Assumes: one clock domain, reset arst_n
// Notes:   counter words are seen only through reads
`default_nettype none
module flcu_fast_loop_counter_unit_sva (
  input wire logic                          sys_clk,
  input wire logic                          arst_n,
  input wire logic                          ce,
  input wire logic                          sdwWrEn,
  input wire logic                          sdwRdEn,
  input wire logic [flcu_pkg::FLCU_IDX_W-1:0]  sdwRdIdx,
  input wire logic [flcu_pkg::FLCU_WORD_W-1:0] sdwRdData_ff,
  input wire logic                          sdwRdValid_ff,
  input wire logic                          loopCallEn,
  input wire logic [flcu_pkg::FLCU_IDX_W-1:0]  loopCallIdx,
  input wire logic                          loopCallDone_ff,
  input wire logic                          loopCallError_ff,
  input wire logic                          rloWrEn,
  input wire logic                          resultOfLogicBit_ff,
  input wire logic [flcu_pkg::FLCU_CC_W-1:0]   condCodes_ff
);
  import flcu_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic callGo = ce && loopCallEn;
  a_call_done: assert property (callGo |=> loopCallDone_ff) else $error("call not done");
  a_done_cause: assert property (loopCallDone_ff |-> $past(callGo)) else $error("stray done");
  a_no_error: assert property (!loopCallError_ff) else $error("error raised");
  a_cc_clear: assert property (callGo |=> condCodes_ff == FLCU_CC_CLEARED)
    else $error("codes not cleared");
  a_rd_valid: assert property (ce && sdwRdEn |=> sdwRdValid_ff) else $error("no valid");
  a_flag_match: assert property (callGo ##1 (ce && sdwRdEn && !sdwWrEn && !loopCallEn
    && !rloWrEn && sdwRdIdx == $past(loopCallIdx)) |=>
    resultOfLogicBit_ff == (sdwRdData_ff != FLCU_WORD_RST)) else $error("flag mismatch");
  a_rlo_hold: assert property (ce && !loopCallEn && !rloWrEn |=> $stable(resultOfLogicBit_ff))
    else $error("flag moved");
  a_freeze: assert property (!ce |=> $stable(condCodes_ff) && $stable(resultOfLogicBit_ff))
    else $error("state moved while frozen");
  c_wrap: cover property (callGo ##1 sdwRdEn ##1 sdwRdData_ff == FLCU_WORD_MAX);
  c_last: cover property (callGo ##1 !resultOfLogicBit_ff);
  c_freeze: cover property (!ce && loopCallEn);
endmodule : flcu_fast_loop_counter_unit_sva
bind flcu_fast_loop_counter_unit flcu_fast_loop_counter_unit_sva u_sva (.*);
`default_nettype wire

//--- sim/flcu_fast_loop_counter_unit_tb_top.sv
// Purpose: self-checking bench for the loop counter unit
// Assumes: inputs driven by non-blocking assignment at rising edges
// Notes:   accumulators have no port, so condition state, call status and readback words are observed
`default_nettype none
module flcu_fast_loop_counter_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flcu_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, ce = 1'b0, sdwWrEn = 1'b0, sdwRdEn = 1'b0;
  logic loopCallEn = 1'b0, rloWrEn = 1'b0, rloWrData = 1'b0, ccWrEn = 1'b0;
  logic [FLCU_IDX_W-1:0]  sdwWrIdx = 2'h0, sdwRdIdx = 2'h0, loopCallIdx = 2'h0;
  logic [FLCU_WORD_W-1:0] sdwWrData = 16'h0000, sdwRdData_ff;
  logic [FLCU_CC_W-1:0]   ccWrData = 8'h00, condCodes_ff;
  logic sdwRdValid_ff, loopCallDone_ff, loopCallError_ff, resultOfLogicBit_ff;
  logic [15:0] v [4] = '{16'hFFFF, 16'h0001, 16'h8000, 16'h1234};
  int n_fail = 0, total_checks = 0;
  flcu_fast_loop_counter_unit uut (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] idx, input logic [15:0] d);
    @(posedge sys_clk);
    sdwWrEn <= 1'b1;
    sdwWrIdx <= idx;
    sdwWrData <= d;
    @(posedge sys_clk);
    sdwWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] idx, input logic [15:0] exp);
    @(posedge sys_clk);
    sdwRdEn <= 1'b1;
    sdwRdIdx <= idx;
    @(posedge sys_clk);
    sdwRdEn <= 1'b0;
    #1 chk(sdwRdData_ff, exp);
    chk(16'(sdwRdValid_ff), 16'h0001);
  endtask : rd
  // dirty the codes and flag first so the call must really clear or set them
  task automatic call(input logic [1:0] idx, input logic [15:0] w, input logic f);
    @(posedge sys_clk);
    ccWrEn <= 1'b1;
    ccWrData <= 8'hA5;
    rloWrEn <= 1'b1;
    rloWrData <= ~f;
    @(posedge sys_clk);
    {ccWrEn, rloWrEn, loopCallEn} <= 3'h1;
    loopCallIdx <= idx;
    #1 chk(16'(condCodes_ff), 16'h00A5);
    @(posedge sys_clk);
    loopCallEn <= 1'b0;
    sdwRdEn <= 1'b1;
    sdwRdIdx <= idx;
    #1 chk(16'(loopCallDone_ff), 16'h0001);
    chk(16'(condCodes_ff), 16'(FLCU_CC_CLEARED));
    chk(16'(resultOfLogicBit_ff), 16'(f));
    chk(16'(loopCallError_ff), 16'h0000);
    @(posedge sys_clk);
    sdwRdEn <= 1'b0;
    #1 chk(sdwRdData_ff, w);
  endtask : call
  task automatic t_map;
    for (int i = 0; i < 4; i++) wr(2'(i), v[i]);
    for (int i = 0; i < 4; i++) call(2'(i), v[i] - 16'h0001, v[i] != 16'h0001);
    for (int i = 0; i < 4; i++) rd(2'(i), v[i] - 16'h0001);
  endtask : t_map
  task automatic t_wrap;
    wr(2'h3, 16'h0000);
    call(2'h3, FLCU_WORD_MAX, 1'b1);
  endtask : t_wrap
  task automatic t_loop;
    wr(2'h1, 16'h0003);
    for (int n = 1; n <= 3; n++) call(2'h1, 16'(3 - n), n != 3);
  endtask : t_loop
  task automatic t_freeze;
    wr(2'h0, 16'h0005);
    @(posedge sys_clk);
    ce <= 1'b0;
    {loopCallEn, sdwWrEn} <= 2'h3;
    loopCallIdx <= 2'h0;
    sdwWrData <= 16'h0009;
    @(posedge sys_clk);
    ce <= 1'b1;
    {loopCallEn, sdwWrEn} <= 2'h0;
    rd(2'h0, 16'h0005);
  endtask : t_freeze
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // about 66 cycles of work; a wide margin still ends a hang quickly
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    ce <= 1'b1;
    rd(2'h2, FLCU_WORD_RST);
    t_map();
    t_wrap();
    t_loop();
    t_freeze();
    print_verdict();
  end
endmodule : flcu_fast_loop_counter_unit_tb_top
`default_nettype wire
